// *** cfg_regs_pkg.sv ***
package cfg_regs_pkg;

    localparam logic [7:0]  OFFSET_DEVICE_IDENT    = 8'h02;
    localparam logic [7:0]  OFFSET_COMMAND_CONTROL = 8'h04;
    localparam logic [5:0]  DWORD_IDENT            = 6'h00;
    localparam logic [5:0]  DWORD_COMMAND          = 6'h01;

    localparam logic [15:0] COMMAND_RESET          = 16'h0006;
    localparam logic [15:0] COMMAND_HW_ONES        = 16'h0006;
    localparam int          SYSERR_ENABLE_BIT      = 8;
    localparam int          SIGNALLED_FLAG_BIT     = 14;
    localparam logic        FLAG_RESET             = 1'h0;

    // Arbitrary neutral value, not a real part code
    localparam logic [15:0] DEVICE_IDENT_VALUE     = 16'h5a5a;

    typedef struct packed {
        logic        write;
        logic        read;
        logic [7:0]  offset;
        logic [3:0]  byte_en;
        logic [31:0] wdata;
    } cfg_req_s;

endpackage

// *** syserr_msg_sender.sv ***
`timescale 1ns/10ps
module syserr_msg_sender (
    input  wire logic clock,
    input  wire logic reset,
    input  wire logic send,
    input  wire logic msg_ready,
    output logic      msg_valid
);

    // Events arriving while a message waits merge into it
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            msg_valid <= 1'h0;
        end else begin
            msg_valid <= send | (msg_valid & ~msg_ready);
        end
    end

endmodule // syserr_msg_sender

// *** host_bridge_command_id_regs.sv ***
`timescale 1ns/10ps
// Behaviour
// R1: Device ident is a fixed 16-bit read-only value; writes change nothing.
// R2: Command register is 16 bits at offset 04h, reads 0006h after reset.
// R3: With bit 8 set, enabled error events send a system-error hub message.
// R4: With bit 8 clear, no system-error message is sent for this function.
// R5: No system-error pin; errors are reported only by hub message.
// R6: Message mechanism enabled by OR of both functions' enables.
// R7: Bit 9 fast back-to-back reads zero, ignores writes.
// R8: Bits 7 to 3 are hardwired zero, unaffected by writes.
// R9: Peripheral bus special cycles are ignored; bit 3 stays zero.
// R10: Bit 2 bus master permit is hardwired one.
// R11: Bit 1 memory space permit is hardwired one.
// R12: Bit 0 I/O space permit is hardwired zero.
// R13: Bits 15 to 10 read zero and discard writes.
// R14: Registers are reached by configuration reads and writes of function zero.
// R15: Sending a message for this function's error sets the signalled flag; writing one clears it.
module host_bridge_command_id_regs (
    input  wire logic                    clock,
    input  wire logic                    reset,
    input  wire cfg_regs_pkg::cfg_req_s  cfg_req,
    output logic [31:0]                  cfg_rdata,
    output logic                         cfg_rvalid,
    input  wire logic                    err_event,
    input  wire logic                    fn1_syserr_enable,
    input  wire logic                    fn1_err_event,
    output logic                         hub_msg_valid,
    input  wire logic                    hub_msg_ready,
    output logic                         syserr_msg_enable
);

    logic        syserr_signalled_flag;
    logic [5:0]  dword;
    logic        cmd_hit;
    logic        fn0_send;
    logic        fn1_send;
    logic        send;
    logic        flag_clear;
    logic        mechanism_enable;
    logic [15:0] command_control;
    logic [15:0] status_view;
    logic        ident_hit;
    logic        unmapped_hit;
    logic        cmd_read;
    logic        enable_write;

    assign dword            = cfg_req.offset[7:2];
    assign cmd_hit          = (dword == cfg_regs_pkg::DWORD_COMMAND);
    assign ident_hit        = (dword == cfg_regs_pkg::DWORD_IDENT);
    assign unmapped_hit     = ~ident_hit & ~cmd_hit;
    assign cmd_read         = cfg_req.read & cmd_hit;
    assign enable_write     = cfg_req.write & cmd_hit & cfg_req.byte_en[1];
    assign mechanism_enable = syserr_msg_enable | fn1_syserr_enable; // [R6]
    assign fn0_send         = err_event & syserr_msg_enable; // [R3] [R4]
    assign fn1_send         = fn1_err_event & fn1_syserr_enable;
    assign send             = mechanism_enable & (fn0_send | fn1_send); // [R6]
    assign flag_clear       = cfg_req.write & cmd_hit & cfg_req.byte_en[3]
                              & cfg_req.wdata[16 + cfg_regs_pkg::SIGNALLED_FLAG_BIT]; // [R15]

    // Only bit 8 is storage; hardwired bits never see a write
    assign command_control = cfg_regs_pkg::COMMAND_HW_ONES // [R10] [R11] [R7] [R8] [R9] [R12] [R13]
                             | ({15'h0000, syserr_msg_enable} << cfg_regs_pkg::SYSERR_ENABLE_BIT); // [R3]
    assign status_view     = {1'h0, syserr_signalled_flag, 14'h0000};

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            syserr_msg_enable <= cfg_regs_pkg::COMMAND_RESET[cfg_regs_pkg::SYSERR_ENABLE_BIT]; // [R2]
        end else if (cfg_req.write && cmd_hit && cfg_req.byte_en[1]) begin
            syserr_msg_enable <= cfg_req.wdata[cfg_regs_pkg::SYSERR_ENABLE_BIT]; // [R14]
        end
    end

    // Set beats clear so an event in the clearing cycle is kept
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            syserr_signalled_flag <= cfg_regs_pkg::FLAG_RESET;
        end else if (fn0_send) begin
            syserr_signalled_flag <= 1'h1; // [R15]
        end else if (flag_clear) begin
            syserr_signalled_flag <= 1'h0; // [R15]
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            cfg_rdata  <= 32'h00000000;
            cfg_rvalid <= 1'h0;
        end else begin
            cfg_rvalid <= cfg_req.read; // [R14]
            if (cfg_req.read) begin
                case (dword)
                    cfg_regs_pkg::DWORD_IDENT:   cfg_rdata <= {cfg_regs_pkg::DEVICE_IDENT_VALUE, 16'h0000}; // [R1]
                    cfg_regs_pkg::DWORD_COMMAND: cfg_rdata <= {status_view, command_control}; // [R2]
                    default:                     cfg_rdata <= 32'h00000000;
                endcase
            end
        end
    end

    // Hub message is the only error report path; no pin exists
    syserr_msg_sender sender (
        .clock     (clock),
        .reset     (reset),
        .send      (send),
        .msg_ready (hub_msg_ready),
        .msg_valid (hub_msg_valid)
    ); // [R5]

    AST_IDENT_FIXED: assert property (@(posedge clock) disable iff (reset) // [R1]
        (cfg_req.read && dword == cfg_regs_pkg::DWORD_IDENT)
        |=> (cfg_rvalid && cfg_rdata[31:16] == cfg_regs_pkg::DEVICE_IDENT_VALUE))
        else $error("device ident read wrong");

    AST_CMD_SHAPE: assert property (@(posedge clock) disable iff (reset) // [R2]
        (cfg_req.read && cmd_hit)
        |=> (cfg_rdata[15:9] == 7'h00 && cfg_rdata[7:0] == 8'h06
             && cfg_rdata[8] == $past(syserr_msg_enable)))
        else $error("command read shows wrong fixed bits");

    AST_ENABLE_WRITE: assert property (@(posedge clock) disable iff (reset) // [R3]
        (cfg_req.write && cmd_hit && cfg_req.byte_en[1])
        |=> (syserr_msg_enable == $past(cfg_req.wdata[8])))
        else $error("message enable did not take write");

    AST_SEND_ENABLED: assert property (@(posedge clock) disable iff (reset) // [R3]
        (err_event && syserr_msg_enable) |=> hub_msg_valid)
        else $error("enabled error raised no message");

    AST_NO_SEND_DISABLED: assert property (@(posedge clock) disable iff (reset) // [R4]
        (!hub_msg_valid && !(err_event && syserr_msg_enable)
         && !(fn1_err_event && fn1_syserr_enable)) |=> !hub_msg_valid)
        else $error("message without enabled cause");

    AST_FN1_SEND: assert property (@(posedge clock) disable iff (reset) // [R6]
        (fn1_err_event && fn1_syserr_enable && !syserr_msg_enable) |=> hub_msg_valid)
        else $error("second function enable ignored");

    AST_MSG_HOLD: assert property (@(posedge clock) disable iff (reset) // [R5]
        (hub_msg_valid && !hub_msg_ready) |=> hub_msg_valid)
        else $error("message dropped before acceptance");

    AST_FLAG_SET: assert property (@(posedge clock) disable iff (reset) // [R15]
        (err_event && syserr_msg_enable) |=> syserr_signalled_flag ##0 hub_msg_valid)
        else $error("signalled flag not set");

    AST_FLAG_CLEAR: assert property (@(posedge clock) disable iff (reset) // [R15]
        (syserr_signalled_flag && flag_clear && !fn0_send) |=> !syserr_signalled_flag)
        else $error("write one did not clear flag");

    AST_FLAG_STICKY: assert property (@(posedge clock) disable iff (reset) // [R15]
        (syserr_signalled_flag && !flag_clear) |=> syserr_signalled_flag)
        else $error("signalled flag lost");

    AST_RESET_STATE: assert property (@(posedge clock) // [R2]
        reset
        |=> (!cfg_rvalid && cfg_rdata == 32'h00000000 && !hub_msg_valid
             && !syserr_msg_enable && !syserr_signalled_flag))
        else $error("state not cleared by reset");

    AST_RVALID_AFTER_READ: assert property (@(posedge clock) disable iff (reset) // [R14]
        cfg_req.read
        |=> cfg_rvalid)
        else $error("read gave no valid pulse");

    AST_RVALID_ONLY_READ: assert property (@(posedge clock) disable iff (reset) // [R14]
        !cfg_req.read
        |=> !cfg_rvalid)
        else $error("valid pulse without a read");

    AST_RDATA_HOLDS: assert property (@(posedge clock) disable iff (reset) // [R14]
        !cfg_req.read
        |=> $stable(cfg_rdata))
        else $error("read data moved without a read");

    AST_UNMAPPED_ZERO: assert property (@(posedge clock) disable iff (reset) // [R14]
        (cfg_req.read && unmapped_hit)
        |=> (cfg_rdata == 32'h00000000))
        else $error("unmapped read not zero");

    AST_IDENT_LOW_HALF: assert property (@(posedge clock) disable iff (reset) // [R1]
        (cfg_req.read && ident_hit)
        |=> (cfg_rdata[15:0] == 16'h0000))
        else $error("ident dword low half not zero");

    AST_IDENT_WRITE_NO_EFFECT: assert property (@(posedge clock) disable iff (reset) // [R1]
        (cfg_req.write && ident_hit)
        |=> $stable(syserr_msg_enable))
        else $error("ident write changed state");

    AST_IDENT_WRITE_FLAG: assert property (@(posedge clock) disable iff (reset) // [R1]
        (cfg_req.write && ident_hit && !fn0_send)
        |=> $stable(syserr_signalled_flag))
        else $error("ident write changed flag");

    AST_FAST_B2B_ZERO: assert property (@(posedge clock) disable iff (reset) // [R7]
        cmd_read
        |=> !cfg_rdata[9])
        else $error("bit 9 not zero");

    AST_FIXED_ZEROS: assert property (@(posedge clock) disable iff (reset) // [R8]
        cmd_read
        |=> (cfg_rdata[7:3] == 5'h00))
        else $error("bits 7 to 3 not zero");

    AST_SPECIAL_CYCLE_OFF: assert property (@(posedge clock) disable iff (reset) // [R9]
        cmd_read
        |=> !cfg_rdata[3])
        else $error("bit 3 not zero");

    AST_BUS_MASTER_ON: assert property (@(posedge clock) disable iff (reset) // [R10]
        cmd_read
        |=> cfg_rdata[2])
        else $error("bus master bit not one");

    AST_MEMORY_ON: assert property (@(posedge clock) disable iff (reset) // [R11]
        cmd_read
        |=> cfg_rdata[1])
        else $error("memory space bit not one");

    AST_IO_OFF: assert property (@(posedge clock) disable iff (reset) // [R12]
        cmd_read
        |=> !cfg_rdata[0])
        else $error("io space bit not zero");

    AST_RESERVED_ZERO: assert property (@(posedge clock) disable iff (reset) // [R13]
        cmd_read
        |=> (cfg_rdata[15:10] == 6'h00))
        else $error("reserved bits not zero");

    AST_STATUS_SHOWN: assert property (@(posedge clock) disable iff (reset) // [R15]
        cmd_read
        |=> (cfg_rdata[31:16] == {1'h0, $past(syserr_signalled_flag), 14'h0000}))
        else $error("status half wrong");

    AST_ENABLE_HOLDS: assert property (@(posedge clock) disable iff (reset) // [R3]
        !enable_write
        |=> $stable(syserr_msg_enable))
        else $error("enable moved without a write");

    AST_OTHER_LANES_IGNORED: assert property (@(posedge clock) disable iff (reset) // [R13]
        (cfg_req.write && cmd_hit && !cfg_req.byte_en[1])
        |=> $stable(syserr_msg_enable))
        else $error("enable taken from wrong lane");

    AST_UNMAPPED_WRITE: assert property (@(posedge clock) disable iff (reset) // [R14]
        (cfg_req.write && unmapped_hit)
        |=> $stable(syserr_msg_enable))
        else $error("unmapped write changed enable");

    AST_ENABLE_SET_WRITE: assert property (@(posedge clock) disable iff (reset) // [R3]
        (enable_write && cfg_req.wdata[cfg_regs_pkg::SYSERR_ENABLE_BIT])
        |=> syserr_msg_enable)
        else $error("enable not set by write");

    AST_ENABLE_CLEAR_WRITE: assert property (@(posedge clock) disable iff (reset) // [R4]
        (enable_write && !cfg_req.wdata[cfg_regs_pkg::SYSERR_ENABLE_BIT])
        |=> !syserr_msg_enable)
        else $error("enable not cleared by write");

    AST_FLAG_FN0_ONLY: assert property (@(posedge clock) disable iff (reset) // [R15]
        (!syserr_signalled_flag && !fn0_send)
        |=> !syserr_signalled_flag)
        else $error("flag set without own message");

    AST_FN1_NO_FLAG: assert property (@(posedge clock) disable iff (reset) // [R15]
        (!syserr_signalled_flag && fn1_send && !fn0_send)
        |=> !syserr_signalled_flag)
        else $error("second function set the flag");

    AST_SET_BEATS_CLEAR: assert property (@(posedge clock) disable iff (reset) // [R15]
        (fn0_send && flag_clear)
        |=> syserr_signalled_flag)
        else $error("clear beat a new event");

    AST_CLEAR_NEEDS_LANE: assert property (@(posedge clock) disable iff (reset) // [R15]
        (syserr_signalled_flag && cfg_req.write && cmd_hit && !cfg_req.byte_en[3])
        |=> syserr_signalled_flag)
        else $error("flag cleared from wrong lane");

    AST_FLAG_NEEDS_ENABLE: assert property (@(posedge clock) disable iff (reset) // [R4]
        (!syserr_signalled_flag && !syserr_msg_enable)
        |=> !syserr_signalled_flag)
        else $error("flag set while disabled");

    AST_FN0_DISABLED_QUIET: assert property (@(posedge clock) disable iff (reset) // [R4]
        (err_event && !syserr_msg_enable && !fn1_err_event && !hub_msg_valid)
        |=> !hub_msg_valid)
        else $error("disabled error raised a message");

    AST_BOTH_OFF_QUIET: assert property (@(posedge clock) disable iff (reset) // [R6]
        (!hub_msg_valid && !syserr_msg_enable && !fn1_syserr_enable)
        |=> !hub_msg_valid)
        else $error("message with both enables off");

    AST_MSG_RELEASE: assert property (@(posedge clock) disable iff (reset) // [R5]
        (hub_msg_valid && hub_msg_ready && !send)
        |=> !hub_msg_valid)
        else $error("accepted message not released");

    AST_SEND_RAISES_MSG: assert property (@(posedge clock) disable iff (reset) // [R5]
        send
        |=> hub_msg_valid)
        else $error("send gave no message");

endmodule // host_bridge_command_id_regs

// *** hub_msg_model.sv ***
`timescale 1ns/10ps
module hub_msg_model (
    input  wire logic       clock,
    input  wire logic       reset,
    input  wire logic       msg_valid,
    input  wire logic       slow,
    output logic            msg_ready,
    output logic [7:0]      accepted
);
    logic [1:0] wait_cnt;
    // Slow mode stalls three cycles to prove the request holds
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wait_cnt  <= 2'h0;
            msg_ready <= 1'h0;
        end else if (msg_valid && !msg_ready && (!slow || wait_cnt == 2'h3)) begin
            msg_ready <= 1'h1;
            wait_cnt  <= 2'h0;
        end else begin
            msg_ready <= 1'h0;
            wait_cnt  <= (msg_valid && !msg_ready) ? wait_cnt + 2'h1 : 2'h0;
        end
    end
    always_ff @(posedge clock or posedge reset) begin
        if (reset) accepted <= 8'h00;
        else if (msg_valid && msg_ready) accepted <= accepted + 8'h01;
    end
endmodule // hub_msg_model

// *** host_bridge_command_id_regs_test.sv ***
`timescale 1ns/10ps
module host_bridge_command_id_regs_test;
    logic clock = 0, reset = 1, err_event = 0, fn1_syserr_enable = 0, fn1_err_event = 0, slow = 0;
    logic hub_msg_valid, hub_msg_ready, syserr_msg_enable, cfg_rvalid, en = 0, flag = 0;
    logic [31:0] cfg_rdata, d, seed = 32'h00014ccb, exp_q[$];
    logic [7:0]  accepted, exp_msgs = 8'h00;
    int fail_count = 0, n_checks = 0;
    cfg_regs_pkg::cfg_req_s cfg_req = '0;
    always #12.5 clock = ~clock;
    host_bridge_command_id_regs uut (.clock(clock), .reset(reset), .cfg_req(cfg_req), .cfg_rdata(cfg_rdata),
        .cfg_rvalid(cfg_rvalid), .err_event(err_event), .fn1_syserr_enable(fn1_syserr_enable),
        .fn1_err_event(fn1_err_event), .hub_msg_valid(hub_msg_valid), .hub_msg_ready(hub_msg_ready),
        .syserr_msg_enable(syserr_msg_enable));
    hub_msg_model hub (.clock(clock), .reset(reset), .msg_valid(hub_msg_valid), .slow(slow),
        .msg_ready(hub_msg_ready), .accepted(accepted));
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] expected);
        n_checks++;
        if (seen !== expected) begin
            fail_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, expected);
        end
    endtask
    task automatic access(input logic wr, input logic [7:0] off, input logic [3:0] be, input logic [31:0] data);
        @(posedge clock);
        cfg_req <= '{write: wr, read: !wr, offset: off, byte_en: be, wdata: data};
        @(posedge clock);
        cfg_req <= '0;
    endtask
    task automatic rd(input logic [7:0] off, input logic [31:0] expected);
        exp_q.push_back(expected);
        access(1'h0, off, 4'h0, 32'h0);
    endtask
    task automatic ev(input logic a, input logic b);
        @(posedge clock);
        err_event     <= a;
        fn1_err_event <= b;
        if ((a && en) || (b && fn1_syserr_enable)) exp_msgs = exp_msgs + 8'h01;
        if (a && en) flag = 1'h1;
        @(posedge clock);
        err_event     <= 1'h0;
        fn1_err_event <= 1'h0;
        repeat (8) @(posedge clock);
        check({24'h0, accepted}, {24'h0, exp_msgs});
    endtask
    function automatic logic [31:0] cmd_word();
        return {1'h0, flag, 14'h0, 16'h0006 | {7'h0, en, 8'h00}};
    endfunction
    always @(posedge clock) begin
        if (cfg_rvalid === 1'h1) begin
            if (exp_q.size() > 0) check(cfg_rdata, exp_q.pop_front());
            else check({31'h0, cfg_rvalid}, 32'h0);
        end
    end
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        #50000;
        fail_count++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clock);
        reset <= 1'h0;
        rd(8'h04, cmd_word());
        rd(8'h02, {cfg_regs_pkg::DEVICE_IDENT_VALUE, 16'h0000});
        seed = lfsr(seed);
        access(1'h1, 8'h00, 4'hf, seed);
        rd(8'h00, {cfg_regs_pkg::DEVICE_IDENT_VALUE, 16'h0000});
        access(1'h1, 8'h08, 4'hf, seed);
        rd(8'h08, 32'h00000000);
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            d = (i == 0) ? 32'hbfffffff : (seed & 32'hbfffffff);
            en = d[8];
            access(1'h1, 8'h04, 4'hf, d);
            rd(8'h04, cmd_word());
            check({31'h0, syserr_msg_enable}, {31'h0, en});
        end
        en = 1'h1;
        access(1'h1, 8'h04, 4'h3, 32'h00000100);
        ev(1'h1, 1'h0);
        rd(8'h04, cmd_word());
        flag = 1'h0;
        access(1'h1, 8'h04, 4'h8, 32'h40000000);
        rd(8'h04, cmd_word());
        en = 1'h0;
        access(1'h1, 8'h04, 4'h2, 32'h00000000);
        ev(1'h1, 1'h0);
        fn1_syserr_enable <= 1'h1;
        slow <= 1'h1;
        ev(1'h0, 1'h1);
        rd(8'h04, cmd_word());
        en = 1'h1;
        access(1'h1, 8'h04, 4'h2, 32'h00000100);
        fork
            access(1'h1, 8'h04, 4'hf, 32'h40000100);
            ev(1'h1, 1'h0);
        join
        rd(8'h04, cmd_word());
        access(1'h1, 8'h04, 4'h7, 32'hffffffff);
        rd(8'h04, cmd_word());
        repeat (2) @(posedge clock);
        reset <= 1'h1;
        repeat (2) @(posedge clock);
        reset <= 1'h0;
        en = 1'h0;
        flag = 1'h0;
        rd(8'h04, cmd_word());
        repeat (4) @(posedge clock);
        check(exp_q.size(), 32'h0);
        give_verdict();
    end
endmodule // host_bridge_command_id_regs_test
